// file: hw/interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module interval_timer
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// control
	input wire logic start,
	input wire logic [31:0] length,
	// status
	output logic expired
);

	logic [31:0] count_r;
	logic running_r;
	logic expired_r;

	assign expired = expired_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			count_r <= 32'h00000000;
			running_r <= 1'b0;
			expired_r <= 1'b0;
		end
		else
		begin
			expired_r <= 1'b0;
			if (start)
			begin
				// expired lands exactly length cycles after start for any nonzero length
				count_r <= (length > 32'h00000001) ? length - 32'h00000002 : 32'h00000000;
				running_r <= (length > 32'h00000001);
				expired_r <= (length <= 32'h00000001);
			end
			else if (running_r)
			begin
				if (count_r == 32'h00000000)
				begin
					running_r <= 1'b0;
					expired_r <= 1'b1;
				end
				else
				begin
					count_r <= count_r - 32'h00000001;
				end
			end
		end
	end

endmodule
`default_nettype wire

// file: hw/node_cfg_pkg.sv
package node_cfg_pkg;

	// clock and time base
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned BLINK_ON_MS = 250;
	localparam int unsigned BLINK_OFF_MS = 250;
	localparam int unsigned DIGIT_GAP_MS = 750;
	localparam int unsigned CODE_SEP_MS = 2500;
	localparam int unsigned FAST_FLASH_MS = 100;
	localparam int unsigned ACT_FLASH_MS = 50;
	localparam int unsigned BLINK_ON_CYC = BLINK_ON_MS * CLK_KHZ;
	localparam int unsigned BLINK_OFF_CYC = BLINK_OFF_MS * CLK_KHZ;
	localparam int unsigned DIGIT_GAP_CYC = DIGIT_GAP_MS * CLK_KHZ;
	localparam int unsigned CODE_SEP_CYC = CODE_SEP_MS * CLK_KHZ;
	localparam int unsigned FAST_FLASH_CYC = FAST_FLASH_MS * CLK_KHZ;
	localparam int unsigned ACT_FLASH_CYC = ACT_FLASH_MS * CLK_KHZ;

	// node address ranges
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'hef;
	localparam logic [7:0] ADDR_TWO_STOP = 8'h20;
	localparam logic [3:0] SPECIAL_UPPER = 4'hf;
	localparam logic [3:0] FUNC_RESTORE = 4'hf;
	localparam logic [3:0] FUNC_APP_A = 4'he;
	localparam logic [3:0] FUNC_STD = 4'hd;

	// factory defaults and limits
	localparam logic [16:0] BAUD_DEFAULT = 17'h02580;
	localparam logic [16:0] BAUD_MAX = 17'h1c200;
	localparam logic [31:0] IP_DEFAULT = 32'hc0a80064;
	localparam logic [31:0] MASK_DEFAULT = 32'hffffff00;
	localparam logic [31:0] GATEWAY_DEFAULT = 32'h00000000;

	// application modes
	typedef enum logic [1:0] {
		APP_STD = 2'h0,
		APP_A = 2'h1,
		APP_CUSTOM = 2'h3
	} app_mode_e;

	// health code digits
	localparam logic [2:0] DIGIT_ERR1 = 3'h1;
	localparam logic [2:0] DIGIT_ERR2 = 3'h1;
	localparam logic [2:0] DIGIT_APP1 = 3'h4;
	localparam logic [2:0] DIGIT_A2 = 3'h1;
	localparam logic [2:0] DIGIT_STD2 = 3'h2;
	localparam logic [2:0] DIGIT_CUSTOM2 = 3'h3;

	// health led sequencer, gray along the code path
	typedef enum logic [2:0] {
		ST_SEP = 3'h0,
		ST_ON = 3'h1,
		ST_OFF = 3'h3,
		ST_GAP = 3'h5,
		ST_FAST_ON = 3'h6,
		ST_FAST_OFF = 3'h7
	} health_state_e;

endpackage

// file: hw/node_config_and_status_led.sv
// How it works
// - switch bank read as binary address, switch one is the low bit
// - addresses 1 to 239 flagged valid for serial and CAN
// - codes 240 to 255 are never valid node addresses
// - special mode only when switches five to eight closed at power-up
// - special mode with one to four closed restores baud and network settings
// - special mode, switch one open, two to four closed: application A
// - special mode, switch two open, others closed: standard application
// - one stop bit for addresses 1 to 31, two for 32 to 239
// - default baud 9600, writes above 115200 are refused
// - default network: 192.168.0.100, 255.255.255.0, gateway 0.0.0.0
// - standard application unless something else is selected
// - health led shows two digit blink codes for each mode
// - each blink is quarter second on, quarter second off
// - three quarter second off between the two digits
// - two and a half second pause between code repetitions
// - bootloader: health led flashes 100 ms on, 100 ms off
// - ethernet activity led flashes on traffic, link led steady on link
// - one speed led for 100 Mbit, another for 10 Mbit
// - CAN led lit while transmitting or receiving
`timescale 1ns/100ps
`default_nettype none
module node_config_and_status_led
	import node_cfg_pkg::*;
#(
	parameter logic [31:0] BLINK_ON_LEN = BLINK_ON_CYC,
	parameter logic [31:0] BLINK_OFF_LEN = BLINK_OFF_CYC,
	parameter logic [31:0] DIGIT_GAP_LEN = DIGIT_GAP_CYC,
	parameter logic [31:0] CODE_SEP_LEN = CODE_SEP_CYC,
	parameter logic [31:0] FAST_FLASH_LEN = FAST_FLASH_CYC,
	parameter logic [31:0] ACT_FLASH_LEN = ACT_FLASH_CYC
)
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// configuration switches, closed reads as one
	input wire logic [7:0] node_address_switches,
	input wire logic can_termination_switch,
	input wire logic serial_termination_switch,
	// firmware settings
	input wire logic baud_wr,
	input wire logic [16:0] baud_value,
	input wire logic net_wr,
	input wire logic [31:0] ip_value,
	input wire logic [31:0] mask_value,
	input wire logic [31:0] gateway_value,
	input wire logic custom_app_req,
	// firmware status
	input wire logic startup_error,
	input wire logic bootloader_mode,
	// network port status
	input wire logic [1:0] eth_activity,
	input wire logic [1:0] eth_link_up,
	input wire logic [1:0] eth_speed_100,
	input wire logic can_tx_active,
	input wire logic can_rx_active,
	// configuration results
	output logic [7:0] node_address,
	output logic address_valid,
	output logic two_stop_bits,
	output logic config_ready,
	output logic restore_defaults,
	output logic [1:0] app_mode,
	output logic [16:0] baud_rate,
	output logic [31:0] ip_address,
	output logic [31:0] net_mask,
	output logic [31:0] gateway,
	output logic can_termination_en,
	output logic serial_termination_en,
	// indicators
	output logic health_indicator_led,
	output logic [1:0] eth_act_led,
	output logic [1:0] eth_link_led,
	output logic [1:0] eth_led_100,
	output logic [1:0] eth_led_10,
	output logic can_led
);

	function automatic logic is_valid_addr(input logic [7:0] a);
		is_valid_addr = (a >= ADDR_MIN) && (a <= ADDR_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// power-up capture and function decode

	logic captured_r;
	logic evaluated_r;
	logic [7:0] node_address_r;
	logic address_valid_r;
	logic two_stop_bits_r;
	logic restore_r;
	logic can_term_r;
	logic serial_term_r;
	app_mode_e app_mode_r;
	app_mode_e app_mode_nxt;
	logic special_mode;
	logic [3:0] func_code;
	logic do_decode;

	assign special_mode = node_address_r[7:4] == SPECIAL_UPPER;
	assign func_code = node_address_r[3:0];
	assign do_decode = captured_r && !evaluated_r;

	always_comb
	begin
		app_mode_nxt = app_mode_r;
		if (do_decode && special_mode)
		begin
			if (func_code == FUNC_APP_A)
				app_mode_nxt = APP_A;
			else if (func_code == FUNC_STD)
				app_mode_nxt = APP_STD;
		end
		else if (custom_app_req)
		begin
			app_mode_nxt = APP_CUSTOM;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			captured_r <= 1'b0;
			evaluated_r <= 1'b0;
			node_address_r <= 8'h00;
			address_valid_r <= 1'b0;
			two_stop_bits_r <= 1'b0;
			restore_r <= 1'b0;
			can_term_r <= 1'b0;
			serial_term_r <= 1'b0;
			app_mode_r <= APP_STD;
		end
		else
		begin
			// straps caught once, first edge after release
			if (!captured_r)
			begin
				captured_r <= 1'b1;
				node_address_r <= node_address_switches;
				address_valid_r <= is_valid_addr(node_address_switches);
				two_stop_bits_r <= node_address_switches >= ADDR_TWO_STOP;
			end
			evaluated_r <= captured_r;
			restore_r <= do_decode && special_mode && func_code == FUNC_RESTORE;
			can_term_r <= can_termination_switch;
			serial_term_r <= serial_termination_switch;
			app_mode_r <= app_mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// nonvolatile settings mirror

	logic [16:0] baud_r;
	logic [31:0] ip_r;
	logic [31:0] mask_r;
	logic [31:0] gateway_r;
	logic baud_ok;

	assign baud_ok = (baud_value != 17'h00000) && (baud_value <= BAUD_MAX);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			baud_r <= BAUD_DEFAULT;
			ip_r <= IP_DEFAULT;
			mask_r <= MASK_DEFAULT;
			gateway_r <= GATEWAY_DEFAULT;
		end
		else if (restore_r)
		begin
			// restore beats a firmware write in the same cycle
			baud_r <= BAUD_DEFAULT;
			ip_r <= IP_DEFAULT;
			mask_r <= MASK_DEFAULT;
			gateway_r <= GATEWAY_DEFAULT;
		end
		else
		begin
			if (baud_wr && baud_ok)
				baud_r <= baud_value;
			if (net_wr)
			begin
				ip_r <= ip_value;
				mask_r <= mask_value;
				gateway_r <= gateway_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// health led sequencer

	health_state_e state_r;
	health_state_e state_nxt;
	logic second_r;
	logic second_nxt;
	logic [2:0] blinks_r;
	logic [2:0] blinks_nxt;
	logic [2:0] digit2_r;
	logic [2:0] digit2_nxt;
	logic kick_r;
	logic tmr_expired;
	logic tmr_start;
	logic [31:0] tmr_length;
	logic [2:0] code_d1;
	logic [2:0] code_d2;
	logic health_led_r;

	assign code_d1 = startup_error ? DIGIT_ERR1 : DIGIT_APP1;
	assign code_d2 = startup_error ? DIGIT_ERR2 :
		(app_mode_r == APP_A) ? DIGIT_A2 :
		(app_mode_r == APP_CUSTOM) ? DIGIT_CUSTOM2 : DIGIT_STD2;

	always_comb
	begin
		state_nxt = state_r;
		second_nxt = second_r;
		blinks_nxt = blinks_r;
		digit2_nxt = digit2_r;
		if (bootloader_mode && state_r != ST_FAST_ON && state_r != ST_FAST_OFF)
		begin
			state_nxt = ST_FAST_ON;
		end
		else
		begin
			case (state_r)
			ST_SEP:
				if (tmr_expired)
				begin
					state_nxt = ST_ON;
					second_nxt = 1'b0;
					blinks_nxt = code_d1;
					digit2_nxt = code_d2;
				end
			ST_ON:
				if (tmr_expired)
				begin
					blinks_nxt = blinks_r - 3'h1;
					if (blinks_r > 3'h1)
						state_nxt = ST_OFF;
					else if (!second_r)
					begin
						state_nxt = ST_GAP;
						second_nxt = 1'b1;
						blinks_nxt = digit2_r;
					end
					else
						state_nxt = ST_SEP;
				end
			ST_OFF:
				if (tmr_expired)
					state_nxt = ST_ON;
			ST_GAP:
				if (tmr_expired)
					state_nxt = ST_ON;
			ST_FAST_ON:
				if (!bootloader_mode)
					state_nxt = ST_SEP;
				else if (tmr_expired)
					state_nxt = ST_FAST_OFF;
			ST_FAST_OFF:
				if (!bootloader_mode)
					state_nxt = ST_SEP;
				else if (tmr_expired)
					state_nxt = ST_FAST_ON;
			default:
				state_nxt = ST_SEP;
			endcase
		end
	end

	// every state entry restarts the timer with that state's length
	assign tmr_start = kick_r || (state_nxt != state_r);
	assign tmr_length = (state_nxt == ST_ON) ? BLINK_ON_LEN :
		(state_nxt == ST_OFF) ? BLINK_OFF_LEN :
		(state_nxt == ST_GAP) ? DIGIT_GAP_LEN :
		(state_nxt == ST_SEP) ? CODE_SEP_LEN : FAST_FLASH_LEN;

	interval_timer u_timer
	(
		.clock(clock),
		.resetn(resetn),
		.start(tmr_start),
		.length(tmr_length),
		.expired(tmr_expired)
	);

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_SEP;
			second_r <= 1'b0;
			blinks_r <= 3'h0;
			digit2_r <= 3'h0;
			kick_r <= 1'b1;
			health_led_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			second_r <= second_nxt;
			blinks_r <= blinks_nxt;
			digit2_r <= digit2_nxt;
			kick_r <= 1'b0;
			health_led_r <= (state_nxt == ST_ON) || (state_nxt == ST_FAST_ON);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// port indicators

	logic [31:0] flash_cnt_r;
	logic flash_phase_r;
	logic [1:0] act_led_r;
	logic [1:0] link_led_r;
	logic [1:0] led100_r;
	logic [1:0] led10_r;
	logic can_led_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			flash_cnt_r <= 32'h00000000;
			flash_phase_r <= 1'b0;
			act_led_r <= 2'h0;
			link_led_r <= 2'h0;
			led100_r <= 2'h0;
			led10_r <= 2'h0;
			can_led_r <= 1'b0;
		end
		else
		begin
			// shared flash base keeps both ports blinking in step
			if (flash_cnt_r >= ACT_FLASH_LEN - 32'h00000001)
			begin
				flash_cnt_r <= 32'h00000000;
				flash_phase_r <= !flash_phase_r;
			end
			else
			begin
				flash_cnt_r <= flash_cnt_r + 32'h00000001;
			end
			act_led_r <= eth_activity & {2{flash_phase_r}};
			link_led_r <= eth_link_up;
			led100_r <= eth_link_up & eth_speed_100;
			led10_r <= eth_link_up & ~eth_speed_100;
			can_led_r <= can_tx_active || can_rx_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign node_address = node_address_r;
	assign address_valid = address_valid_r;
	assign two_stop_bits = two_stop_bits_r;
	assign config_ready = evaluated_r;
	assign restore_defaults = restore_r;
	assign app_mode = app_mode_r;
	assign baud_rate = baud_r;
	assign ip_address = ip_r;
	assign net_mask = mask_r;
	assign gateway = gateway_r;
	assign can_termination_en = can_term_r;
	assign serial_termination_en = serial_term_r;
	assign health_indicator_led = health_led_r;
	assign eth_act_led = act_led_r;
	assign eth_link_led = link_led_r;
	assign eth_led_100 = led100_r;
	assign eth_led_10 = led10_r;
	assign can_led = can_led_r;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_latch_stable;
		@(posedge clock) disable iff (!resetn)
		captured_r |=> $stable(node_address_r);
	endproperty
	a_latch_stable: assert property (p_latch_stable) else $error("address changed after latch");

	property p_valid_range;
		@(posedge clock) disable iff (!resetn)
		captured_r |-> address_valid_r == is_valid_addr(node_address_r);
	endproperty
	a_valid_range: assert property (p_valid_range) else $error("address valid flag wrong");

	property p_reserved;
		@(posedge clock) disable iff (!resetn)
		(captured_r && node_address_r >= 8'hf0) |-> !address_valid_r;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code taken as address");

	property p_stop_bits;
		@(posedge clock) disable iff (!resetn)
		(captured_r && address_valid_r) |-> two_stop_bits_r == (node_address_r > 8'h1f);
	endproperty
	a_stop_bits: assert property (p_stop_bits) else $error("stop bit count wrong");

	property p_restore_once;
		@(posedge clock) disable iff (!resetn)
		restore_r |-> special_mode ##1 !restore_r [*3];
	endproperty
	a_restore_once: assert property (p_restore_once) else $error("restore not a single pulse");

	property p_restore_values;
		@(posedge clock) disable iff (!resetn)
		restore_r |=> baud_r == BAUD_DEFAULT && ip_r == IP_DEFAULT && mask_r == MASK_DEFAULT
			&& gateway_r == GATEWAY_DEFAULT;
	endproperty
	a_restore_values: assert property (p_restore_values) else $error("defaults not restored");

	property p_baud_limit;
		@(posedge clock) disable iff (!resetn)
		baud_r <= BAUD_MAX && baud_r != 17'h00000;
	endproperty
	a_baud_limit: assert property (p_baud_limit) else $error("baud out of range");

	property p_app_a;
		@(posedge clock) disable iff (!resetn)
		(do_decode && special_mode && func_code == FUNC_APP_A) |=> app_mode_r == APP_A;
	endproperty
	a_app_a: assert property (p_app_a) else $error("application A not selected");

	property p_boot_flash;
		@(posedge clock) disable iff (!resetn)
		bootloader_mode [*2] |-> (state_r == ST_FAST_ON || state_r == ST_FAST_OFF);
	endproperty
	a_boot_flash: assert property (p_boot_flash) else $error("no fast flash in bootloader");

	property p_can_led;
		@(posedge clock) disable iff (!resetn)
		##1 can_led_r == $past(can_tx_active || can_rx_active);
	endproperty
	a_can_led: assert property (p_can_led) else $error("can led mismatch");

	property p_speed_leds;
		@(posedge clock) disable iff (!resetn)
		((led100_r & led10_r) == 2'h0) && ((led100_r | led10_r) == link_led_r);
	endproperty
	a_speed_leds: assert property (p_speed_leds) else $error("speed leds inconsistent");

	property p_led_state;
		@(posedge clock) disable iff (!resetn)
		health_led_r |-> (state_r == ST_ON || state_r == ST_FAST_ON);
	endproperty
	a_led_state: assert property (p_led_state) else $error("health led lit off-phase");

endmodule
`default_nettype wire

// file: tb/front_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module front_panel_model
(
	// lever positions set by the bench
	input wire logic [7:0] addr_set,
	input wire logic can_set,
	input wire logic ser_set,
	// switch contacts, closed reads as one
	output logic [7:0] node_address_switches,
	output logic can_termination_switch,
	output logic serial_termination_switch
);
	// contacts settle a little after the lever moves, never on an edge
	assign #3 node_address_switches = addr_set;
	assign #3 can_termination_switch = can_set;
	assign #3 serial_termination_switch = ser_set;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import node_cfg_pkg::*;
;
	logic clock, resetn, can_set, ser_set, baud_wr, net_wr, custom_app_req;
	logic startup_error, bootloader_mode, can_tx_active, can_rx_active;
	logic [7:0] addr_set, node_address_switches, node_address;
	logic can_termination_switch, serial_termination_switch;
	logic [16:0] baud_value, baud_rate;
	logic [31:0] ip_value, mask_value, gateway_value, ip_address, net_mask, gateway;
	logic [1:0] eth_activity, eth_link_up, eth_speed_100, app_mode;
	logic [1:0] eth_act_led, eth_link_led, eth_led_100, eth_led_10;
	logic address_valid, two_stop_bits, config_ready, restore_defaults;
	logic can_termination_en, serial_termination_en, health_indicator_led, can_led;
	int errors = 0;
	int total_checks = 0;
	int restores = 0;

	////////////////////////////////////////////////////////////////////////////
	front_panel_model u_front_panel_model (.addr_set, .can_set, .ser_set,
		.node_address_switches, .can_termination_switch, .serial_termination_switch);

	// short counts keep each code repetition to a few hundred cycles
	// on and off differ so a swapped blink length shows up
	localparam logic [31:0] ON_LEN = 32'h0000000a;
	localparam logic [31:0] OFF_LEN = 32'h0000000c;
	localparam logic [31:0] GAP_LEN = 32'h0000001e;
	localparam logic [31:0] SEP_LEN = 32'h00000064;
	localparam logic [31:0] FAST_LEN = 32'h00000004;
	localparam logic [31:0] ACT_LEN = 32'h00000003;

	node_config_and_status_led #(.BLINK_ON_LEN(ON_LEN), .BLINK_OFF_LEN(OFF_LEN),
		.DIGIT_GAP_LEN(GAP_LEN), .CODE_SEP_LEN(SEP_LEN), .FAST_FLASH_LEN(FAST_LEN),
		.ACT_FLASH_LEN(ACT_LEN)) u_node_config_and_status_led (.clock, .resetn,
		.node_address_switches, .can_termination_switch, .serial_termination_switch,
		.baud_wr, .baud_value, .net_wr, .ip_value, .mask_value, .gateway_value,
		.custom_app_req, .startup_error, .bootloader_mode, .eth_activity, .eth_link_up,
		.eth_speed_100, .can_tx_active, .can_rx_active, .node_address, .address_valid,
		.two_stop_bits, .config_ready, .restore_defaults, .app_mode, .baud_rate,
		.ip_address, .net_mask, .gateway, .can_termination_en, .serial_termination_en,
		.health_indicator_led, .eth_act_led, .eth_link_led, .eth_led_100, .eth_led_10,
		.can_led);

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock)
		if (restore_defaults === 1'b1)
			restores++;

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// inputs always move 2 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic do_reset(input logic [7:0] sw);
		resetn = 1'b0;
		addr_set = sw;
		tick(4);
		restores = 0;
		resetn = 1'b1;
		tick(4);
	endtask

	// firmware writes and a custom request ride the first two edges after release
	task automatic power_up(input logic [7:0] sw);
		resetn = 1'b0;
		addr_set = sw;
		tick(4);
		restores = 0;
		resetn = 1'b1;
		baud_wr = 1'b1;
		baud_value = 17'h1;
		net_wr = 1'b1;
		ip_value = 32'h01020304;
		custom_app_req = 1'b1;
		tick(2);
		baud_wr = 1'b0;
		net_wr = 1'b0;
		custom_app_req = 1'b0;
		tick(2);
	endtask

	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (health_indicator_led === lvl && n < 300)
		begin
			tick(1);
			n++;
		end
	endtask

	// syncs on a full separator, then reads one whole code
	task automatic watch_code(input logic [2:0] d1, input logic [2:0] d2);
		int hi, lo, n, dig;
		logic [2:0] got [2];
		n = 0;
		dig = 0;
		// bounded, so a led stuck at an unknown level cannot spin in zero time
		do
		begin
			run_len(1'b1, hi);
			run_len(1'b0, lo);
			n++;
		end
		while (lo < SEP_LEN && n < 40);
		n = 0;
		while (dig < 2)
		begin
			run_len(1'b1, hi);
			check(hi, ON_LEN);
			n++;
			run_len(1'b0, lo);
			if (lo != OFF_LEN)
			begin
				got[dig] = 3'(n);
				dig++;
				n = 0;
				check(lo, dig == 1 ? GAP_LEN : SEP_LEN);
			end
		end
		check(got[0], d1);
		check(got[1], d2);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic sc_address();
		logic [7:0] tbl [7] = '{8'h00, 8'h01, 8'h05, 8'h1f, 8'h20, 8'hef, 8'hf0};
		foreach (tbl[i])
		begin
			do_reset(tbl[i]);
			check(node_address, tbl[i]);
			check(address_valid, tbl[i] >= 8'h01 && tbl[i] <= 8'hef);
			check(two_stop_bits, tbl[i] >= 8'h20);
			check(config_ready, 1'b1);
			check(restores, 0);
			check(app_mode, APP_STD);
		end
		addr_set = 8'h3c;
		tick(3);
		check(node_address, 8'hf0);
		check(address_valid, 1'b0);
	endtask

	// early writes and custom request make restore and decode visible
	task automatic sc_modes();
		power_up(8'hff);
		check(restores, 1);
		check(baud_rate, BAUD_DEFAULT);
		check(ip_address, IP_DEFAULT);
		check(net_mask, MASK_DEFAULT);
		check(gateway, GATEWAY_DEFAULT);
		power_up(8'h7f);
		check(restores, 0);
		check(baud_rate, 17'h1);
		check(app_mode, APP_CUSTOM);
		power_up(8'hfd);
		check(app_mode, APP_STD);
		watch_code(3'h4, 3'h2);
		power_up(8'hfe);
		check(app_mode, APP_A);
		watch_code(3'h4, 3'h1);
	endtask

	task automatic sc_baud();
		baud_wr = 1'b1;
		baud_value = BAUD_MAX;
		tick(1);
		check(baud_rate, BAUD_MAX);
		baud_value = BAUD_MAX + 17'h1;
		tick(1);
		check(baud_rate, BAUD_MAX);
		baud_value = 17'h0;
		tick(1);
		check(baud_rate, BAUD_MAX);
		baud_value = 17'h1;
		tick(1);
		baud_wr = 1'b0;
		check(baud_rate, 17'h1);
		net_wr = 1'b1;
		ip_value = 32'h0a000001;
		mask_value = 32'hffff0000;
		gateway_value = 32'h0a0000fe;
		tick(1);
		net_wr = 1'b0;
		check(ip_address, 32'h0a000001);
		check(net_mask, 32'hffff0000);
		check(gateway, 32'h0a0000fe);
	endtask

	task automatic sc_health();
		int n;
		custom_app_req = 1'b1;
		tick(1);
		custom_app_req = 1'b0;
		check(app_mode, APP_CUSTOM);
		watch_code(3'h4, 3'h3);
		startup_error = 1'b1;
		watch_code(3'h1, 3'h1);
		startup_error = 1'b0;
		bootloader_mode = 1'b1;
		tick(2);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		check(n, FAST_LEN);
		run_len(1'b0, n);
		check(n, FAST_LEN);
		bootloader_mode = 1'b0;
	endtask

	task automatic sc_leds();
		int n;
		n = 0;
		eth_link_up = 2'b11;
		eth_speed_100 = 2'b01;
		can_tx_active = 1'b1;
		can_set = 1'b1;
		tick(2);
		check(eth_link_led, 2'b11);
		check({eth_led_100, eth_led_10}, 4'b0110);
		check(can_led, 1'b1);
		check({can_termination_en, serial_termination_en}, 2'b10);
		eth_link_up = 2'b10;
		eth_speed_100 = 2'b11;
		can_tx_active = 1'b0;
		can_rx_active = 1'b1;
		can_set = 1'b0;
		ser_set = 1'b1;
		eth_activity = 2'b10;
		tick(2);
		check(eth_link_led, 2'b10);
		check({eth_led_100, eth_led_10}, 4'b1000);
		check(can_led, 1'b1);
		check({can_termination_en, serial_termination_en}, 2'b01);
		repeat (12)
		begin
			check(eth_act_led[0], 1'b0);
			n += (eth_act_led[1] === 1'b1);
			tick(1);
		end
		check(n > 0 && n < 12, 1'b1);
		can_rx_active = 1'b0;
		tick(1);
		check(can_led, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		addr_set = 8'h00;
		can_set = 1'b0;
		ser_set = 1'b0;
		baud_wr = 1'b0;
		baud_value = 17'h0;
		net_wr = 1'b0;
		ip_value = 32'h0;
		mask_value = 32'h0;
		gateway_value = 32'h0;
		custom_app_req = 1'b0;
		startup_error = 1'b0;
		bootloader_mode = 1'b0;
		eth_activity = 2'b00;
		eth_link_up = 2'b00;
		eth_speed_100 = 2'b00;
		can_tx_active = 1'b0;
		can_rx_active = 1'b0;
		sc_address();
		sc_modes();
		sc_baud();
		sc_health();
		sc_leds();
		close_out();
	end

	// whole run is a few thousand cycles; this is over ten times that
	initial
	begin
		repeat (30000) @(posedge clock);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
